// ### ctu_params.svh
// Constants for the charge time unit register bank.
// Assumes inclusion by ctu_pkg.sv and ctu_ctrl.sv.
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define CTU_ADDR_CTRL     12'h000
`define CTU_ADDR_CUR      12'h004
`define CTU_ADDR_IRQ_STAT 12'h008
`define CTU_ADDR_IRQ_EN   12'h00c
`define CTU_ADDR_IRQ_CLR  12'h010

// ------------------------------------------------------------
// Field positions of the edge timing control register
// ------------------------------------------------------------
`define CTU_B_TIME_GEN_ENABLE    12
`define CTU_B_DISCH   9
`define CTU_B_TRIG    8
`define CTU_B_E2POL   7
`define CTU_B_E2SRC_H 6
`define CTU_B_E2SRC_L 5
`define CTU_B_E1POL   4
`define CTU_B_E1SRC_H 3
`define CTU_B_E1SRC_L 2
`define CTU_B_E2FLG   1
`define CTU_B_E1FLG   0

// ------------------------------------------------------------
// Field positions of the current source control register
// ------------------------------------------------------------
`define CTU_B_TRIM_H  15
`define CTU_B_TRIM_L  10
`define CTU_B_RNG_H   9
`define CTU_B_RNG_L   8

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define CTU_RST_CTRL  16'h0000
`define CTU_RST_CUR   16'h0000
`define CTU_CUR_MASK  16'hff00
`define CTU_CTRL_MASK 16'h13ff
`define CTU_IRQ_W     2

`endif

// ### ctu_pkg.sv
// Types shared by the charge time unit register bank.
// Assumes ctu_params.svh is on the include path.
`include "ctu_params.svh"
package ctu_pkg;

  // Edge source selection codes
  typedef enum logic [1:0] {
    CTU_SRC_TIMER = 2'h0,
    CTU_SRC_OC    = 2'h1,
    CTU_SRC_PIN2  = 2'h2,
    CTU_SRC_PIN1  = 2'h3
  } ctu_src_e;

  // Edge sources presented by the surrounding logic
  typedef struct packed {
    logic edge_pin_one;
    logic edge_pin_two;
    logic output_compare_one;
    logic first_timer;
  } ctu_edges_s;

  // Controls handed to the analog current source
  typedef struct packed {
    logic [5:0] current_trim;
    logic [1:0] current_range;
    logic       source_discharge;
  } ctu_analog_s;

endpackage

// ### ctu_ctrl.sv
// Charge time unit control and status register bank on APB.
// Assumes edge sources synchronous to clk_in; analog outside.
`timescale 1ns/10ps
`include "ctu_params.svh"

//  Contract
// - Trigger output follows trigger enable bit
// - Edge two polarity picks rising or falling
// - Edge two source field picks input
// - Edge one polarity picks rising or falling
// - Edge one source field picks input
// - Edge two flag sets on qualified edge
// - Edge one flag sets on qualified edge
// - Six-bit trim passed to current source
// - Two-bit range passed to current source
// - Time gen enable bit turns delay generation
module ctu_ctrl
  import ctu_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                srst_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic                     pready_out,
  output logic                     pslverr_out,
  output logic      [31:0]         prdata_out,
  // Edge sources
  input  wire ctu_pkg::ctu_edges_s edges_in,
  // Analog and unit controls
  output ctu_pkg::ctu_analog_s     analog_out,
  output logic                     trigger_out,
  output logic                     time_gen_enable_out,
  // Interrupt
  output logic                     irq_out
);
  import ctu_pkg::*;

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [15:0]             edge_timing_control;
  logic [15:0]             current_source_control;
  logic [`CTU_IRQ_W-1:0]   irq_stat;
  logic [`CTU_IRQ_W-1:0]   irq_en;
  ctu_edges_s              edges_q;
  logic                    wr_en;
  logic                    rd_en;
  logic                    addr_ok;
  logic                    e1_hit;
  logic                    e2_hit;
  logic [31:0]             next_rdata;

  // Bus strobes; slave answers in the first access cycle
  assign wr_en      = psel_in & penable_in & pwrite_in;
  assign rd_en      = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign addr_ok    = (paddr_in == `CTU_ADDR_CTRL) |
                      (paddr_in == `CTU_ADDR_CUR) |
                      (paddr_in == `CTU_ADDR_IRQ_STAT) |
                      (paddr_in == `CTU_ADDR_IRQ_EN) |
                      (paddr_in == `CTU_ADDR_IRQ_CLR);
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // ----------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------
  // Previous levels; tracks in reset so no false edge follows
  always_ff @(posedge clk_in)
  begin
    edges_q <= edges_in;
  end

  // Pick a source and test its transition against polarity
  function automatic logic edge_hit(input ctu_edges_s cur,
                                    input ctu_edges_s prv,
                                    input logic [1:0] sel,
                                    input logic       pol);
    logic c;
    logic p;
    c = 1'b0;
    p = 1'b0;
    case (ctu_src_e'(sel))
      CTU_SRC_PIN1:
      begin
        c = cur.edge_pin_one;
        p = prv.edge_pin_one;
      end
      CTU_SRC_PIN2:
      begin
        c = cur.edge_pin_two;
        p = prv.edge_pin_two;
      end
      CTU_SRC_OC:
      begin
        c = cur.output_compare_one;
        p = prv.output_compare_one;
      end
      default:
      begin
        c = cur.first_timer;
        p = prv.first_timer;
      end
    endcase
    return pol ? (c & ~p) : (~c & p);
  endfunction

  // Qualified events for both edges
  assign e1_hit = edge_hit(edges_in, edges_q,
    edge_timing_control[`CTU_B_E1SRC_H:`CTU_B_E1SRC_L],
    edge_timing_control[`CTU_B_E1POL]);
  assign e2_hit = edge_hit(edges_in, edges_q,
    edge_timing_control[`CTU_B_E2SRC_H:`CTU_B_E2SRC_L],
    edge_timing_control[`CTU_B_E2POL]);

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  // Edge timing control; an event wins over a software clear
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      edge_timing_control <= `CTU_RST_CTRL;
    else
    begin
      if (wr_en && paddr_in == `CTU_ADDR_CTRL)
        edge_timing_control <= pwdata_in[15:0] & `CTU_CTRL_MASK;
      if (e1_hit)
        edge_timing_control[`CTU_B_E1FLG] <= 1'b1;
      if (e2_hit)
        edge_timing_control[`CTU_B_E2FLG] <= 1'b1;
    end
  end

  // Current source control; low byte never stored
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      current_source_control <= `CTU_RST_CUR;
    else if (wr_en && paddr_in == `CTU_ADDR_CUR)
      current_source_control <= pwdata_in[15:0] & `CTU_CUR_MASK;
  end

  // Interrupt enable
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_en <= '0;
    else if (wr_en && paddr_in == `CTU_ADDR_IRQ_EN)
      irq_en <= pwdata_in[`CTU_IRQ_W-1:0];
  end

  // Sticky interrupt status; set beats write-one clear
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_stat <= '0;
    else
    begin
      if (wr_en && paddr_in == `CTU_ADDR_IRQ_CLR)
        irq_stat <= irq_stat & ~pwdata_in[`CTU_IRQ_W-1:0];
      if (e1_hit)
        irq_stat[0] <= 1'b1;
      if (e2_hit)
        irq_stat[1] <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  // Read mux, unmapped and clear register read zero
  always_comb
  begin
    next_rdata = '0;
    case (paddr_in)
      `CTU_ADDR_CTRL:     next_rdata = {16'h0000, edge_timing_control};
      `CTU_ADDR_CUR:      next_rdata = {16'h0000,
                              current_source_control & `CTU_CUR_MASK};
      `CTU_ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
      `CTU_ADDR_IRQ_EN:   next_rdata = 32'(irq_en);
      default:            next_rdata = '0;
    endcase
  end

  // Read data registered in the setup cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      prdata_out <= '0;
    else if (rd_en)
      prdata_out <= next_rdata;
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Controls straight from register fields
  assign trigger_out = edge_timing_control[`CTU_B_TRIG];
  assign time_gen_enable_out = edge_timing_control[`CTU_B_TIME_GEN_ENABLE];
  assign analog_out.source_discharge =
    edge_timing_control[`CTU_B_DISCH];
  assign analog_out.current_trim =
    current_source_control[`CTU_B_TRIM_H:`CTU_B_TRIM_L];
  assign analog_out.current_range =
    current_source_control[`CTU_B_RNG_H:`CTU_B_RNG_L];
  assign irq_out = |(irq_stat & irq_en);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_trig_follow: assert property (
    @(posedge clk_in) disable iff (srst_in)
    trigger_out == edge_timing_control[`CTU_B_TRIG])
    else $error("trigger output differs from enable bit");

  a_trig_write: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_en && paddr_in == `CTU_ADDR_CTRL) |=>
    trigger_out == $past(pwdata_in[`CTU_B_TRIG]))
    else $error("trigger output not updated");

  a_e2_rise: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (edge_timing_control[`CTU_B_E2POL] &&
     edge_timing_control[`CTU_B_E2SRC_H:`CTU_B_E2SRC_L] == CTU_SRC_PIN1 &&
     $rose(edges_in.edge_pin_one)) |=> edge_timing_control[`CTU_B_E2FLG])
    else $error("rising pin one missed for edge two");

  a_e2_fall: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (!edge_timing_control[`CTU_B_E2POL] &&
     edge_timing_control[`CTU_B_E2SRC_H:`CTU_B_E2SRC_L] == CTU_SRC_TIMER &&
     $fell(edges_in.first_timer)) |=> edge_timing_control[`CTU_B_E2FLG])
    else $error("falling timer missed for edge two");

  a_e2_src: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (edge_timing_control[`CTU_B_E2SRC_H:`CTU_B_E2SRC_L] == CTU_SRC_OC &&
     $stable(edges_in.output_compare_one)) |-> !e2_hit)
    else $error("edge two hit from unselected source");

  a_e1_fall: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (!edge_timing_control[`CTU_B_E1POL] &&
     edge_timing_control[`CTU_B_E1SRC_H:`CTU_B_E1SRC_L] == CTU_SRC_TIMER &&
     $rose(edges_in.first_timer)) |-> !e1_hit)
    else $error("edge one hit on wrong polarity");

  a_e1_src: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (edge_timing_control[`CTU_B_E1SRC_H:`CTU_B_E1SRC_L] == CTU_SRC_PIN2 &&
     edge_timing_control[`CTU_B_E1POL] &&
     $rose(edges_in.edge_pin_two)) |-> e1_hit)
    else $error("edge one missed pin two");

  a_e1_rise: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (edge_timing_control[`CTU_B_E1POL] &&
     edge_timing_control[`CTU_B_E1SRC_H:`CTU_B_E1SRC_L] == CTU_SRC_PIN1 &&
     $rose(edges_in.edge_pin_one)) |=> edge_timing_control[`CTU_B_E1FLG])
    else $error("rising pin one missed for edge one");

  a_quiet: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $stable(edges_in) |-> !e1_hit && !e2_hit)
    else $error("edge event without any source change");

  a_e2_sticky: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (edge_timing_control[`CTU_B_E2FLG] &&
     !(wr_en && paddr_in == `CTU_ADDR_CTRL))
    |=> edge_timing_control[`CTU_B_E2FLG])
    else $error("edge two flag lost");

  a_e2_flag: assert property (
    @(posedge clk_in) disable iff (srst_in)
    e2_hit |=> edge_timing_control[`CTU_B_E2FLG] && irq_stat[1])
    else $error("edge two flag not set");

  a_e1_flag: assert property (
    @(posedge clk_in) disable iff (srst_in)
    e1_hit |=> edge_timing_control[`CTU_B_E1FLG] && irq_stat[0])
    else $error("edge one flag not set");

  a_stat_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_en && paddr_in == `CTU_ADDR_IRQ_CLR && pwdata_in[0] && !e1_hit)
    |=> !irq_stat[0])
    else $error("edge one status not cleared");

  a_trim_out: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_en && paddr_in == `CTU_ADDR_CUR) |=>
    analog_out.current_trim ==
      $past(pwdata_in[`CTU_B_TRIM_H:`CTU_B_TRIM_L]) &&
    analog_out.current_range ==
      $past(pwdata_in[`CTU_B_RNG_H:`CTU_B_RNG_L]))
    else $error("current controls not updated");

  a_cur_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !(wr_en && paddr_in == `CTU_ADDR_CUR) |=>
    $stable(analog_out.current_trim) &&
    $stable(analog_out.current_range))
    else $error("current controls moved without a write");

  a_time_gen_enable_out: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_en && paddr_in == `CTU_ADDR_CTRL) |=>
    time_gen_enable_out == $past(pwdata_in[`CTU_B_TIME_GEN_ENABLE]))
    else $error("time gen enable not updated");

  a_disch_out: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_en && paddr_in == `CTU_ADDR_CTRL) |=>
    analog_out.source_discharge == $past(pwdata_in[`CTU_B_DISCH]))
    else $error("discharge not updated");

  a_low_zero: assert property (
    @(posedge clk_in) disable iff (srst_in)
    current_source_control[`CTU_B_RNG_L-1:0] == '0)
    else $error("current register low byte set");

  a_rd_low: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (rd_en && paddr_in == `CTU_ADDR_CUR) |=>
    prdata_out[`CTU_B_RNG_L-1:0] == '0)
    else $error("current register low byte read nonzero");

  // Main scenarios reached by the bench
  c_e1_event: cover property (@(posedge clk_in) disable iff (srst_in)
    e1_hit);
  c_e2_event: cover property (@(posedge clk_in) disable iff (srst_in)
    e2_hit);
  c_irq: cover property (@(posedge clk_in) disable iff (srst_in)
    $rose(irq_out));
  c_e2_fall: cover property (@(posedge clk_in) disable iff (srst_in)
    e2_hit && !edge_timing_control[`CTU_B_E2POL]);
  c_bus_err: cover property (@(posedge clk_in) disable iff (srst_in)
    pslverr_out);
endmodule

// ### ctu_src_model.sv
// Partner model of the edge sources beside the register bank.
// Assumes the bench requests line levels on rising clk_in edges.
`timescale 1ns/10ps
module ctu_src_model
  import ctu_pkg::*;
(
  // Clock and requested levels
  input  wire logic           clk_in,
  input  wire logic [3:0]     lvl_in,
  // Edge sources
  output ctu_pkg::ctu_edges_s edges_out
);
  import ctu_pkg::*;

  // Each source drives its own routed line, moving after an edge
  always_ff @(posedge clk_in)
  begin
    edges_out <= ctu_edges_s'(lvl_in);
  end
endmodule

// ### edge_timing_unit_control_tb.sv
// Self-checking bench for the charge time unit register bank.
// Assumes ctu_ctrl with zero-wait APB and the edge source model.
`timescale 1ns/10ps
module edge_timing_unit_control_tb;
  import ctu_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_in;
  logic        srst_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        perr;
  logic [3:0]  lvl;
  ctu_edges_s  edges;
  ctu_analog_s analog;
  logic        trig;
  logic        time_gen_enable;
  logic        irq;
  int          miscompares;
  int          num_checks;

  // Design and source model
  ctu_ctrl dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
    .prdata_out(prdata), .edges_in(edges), .analog_out(analog),
    .trigger_out(trig), .time_gen_enable_out(time_gen_enable), .irq_out(irq));
  ctu_src_model src (.clk_in(clk_in), .lvl_in(lvl), .edges_out(edges));

  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude;
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values, current source fields, control outputs, refusals
  task automatic t_regs;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    wr(12'h004, 32'hffff_ffff);
    rd(12'h004, 32'h0000_ff00);
    chk(32'(analog), 32'h1fe);
    wr(12'h004, 32'h0000_8600);
    settle();
    chk(32'(analog), 32'h10c);
    wr(12'h004, 32'h0000_0500);
    settle();
    chk(32'(analog), 32'h00a);
    wr(12'h000, 32'hffff_fffc);
    rd(12'h000, 32'h0000_13fc);
    chk({29'h0, time_gen_enable, analog.source_discharge, trig}, 32'h7);
    wr(12'h000, 32'h0);
    settle();
    chk({29'h0, time_gen_enable, analog.source_discharge, trig}, 32'h0);
    rd(12'h014, 32'h0);
    chk({31'h0, perr}, 32'h1);
    rd(12'h010, 32'h0);
    chk({31'h0, perr}, 32'h0);
  endtask

  // Mid-run reset returns registers and outputs to zero
  task automatic t_rst;
    wr(12'h004, 32'h0000_ff00);
    wr(12'h000, 32'h0000_1303);
    wr(12'h00c, 32'h3);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h00c, 32'h0);
    chk(32'(analog), 32'h0);
    chk({30'h0, time_gen_enable, trig}, 32'h0);
  endtask

  // Source s, edge one on polarity p, edge two on the opposite one
  task automatic t_edge(input logic [1:0] s, input logic p);
    logic [31:0] c;
    c = {24'h0, ~p, s, p, s, 2'b00};
    @(posedge clk_in);
    lvl <= {4{~p}};
    repeat (3) @(posedge clk_in);
    wr(12'h000, c);
    wr(12'h010, 32'h3);
    wr(12'h00c, {30'h0, ~p, p});
    @(posedge clk_in);
    lvl <= {4{~p}} ^ (4'b0001 << (s + 2'd1));
    repeat (3) @(posedge clk_in);
    rd(12'h000, c);
    @(posedge clk_in);
    lvl <= lvl ^ (4'b0001 << s);
    repeat (3) @(posedge clk_in);
    rd(12'h000, c | 32'h1);
    chk({31'h0, irq}, {31'h0, p});
    @(posedge clk_in);
    lvl <= lvl ^ (4'b0001 << s);
    repeat (3) @(posedge clk_in);
    rd(12'h000, c | 32'h3);
    rd(12'h008, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(12'h010, 32'h3);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(12'h008, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    num_checks = 0;
    srst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lvl = 4'h0;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_rst();
    for (int k = 0; k < 8; k++)
      t_edge(k[1:0], k[2]);
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    conclude();
  end
endmodule
